// file: hw/cssu_clock_ctrl.v
// How it works
// - Status register shows ready flag per source
// - PLL ready sets/clears after the lock delay elapses
// - Crystal modes run 1024-cycle startup timer
// - Two-speed wake runs on internal clock
// - Non-crystal modes disable two-speed startup
// - Timer done sets flag, moves to crystal
// - Sleep aborts timer, flag stays clear
`timescale 1ns/1ps
`default_nettype none
`include "cssu_regs.vh"

module cssu_clock_ctrl #(
    parameter CNT_W = 11
)(
    // Clock, reset, enable
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_ce,
    // Crystal oscillator, asynchronous to i_clk
    input  wire        i_xtal_osc,
    // Avalon-MM slave
    input  wire [1:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    // Clock selection to the clock tree
    output reg         o_sel_xtal,
    output reg         o_sel_pll,
    output reg         o_cpu_run
);

    // ****************************************
    // Reset synchroniser
    // ****************************************
    reg rst_s1_reg;
    reg rst_s2_reg;
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire nrst = rst_s2_reg;

    // ****************************************
    // Crystal input synchroniser and edge count
    // ****************************************
    reg xs1_reg;
    reg xs2_reg;
    reg xs3_reg;
    reg xlvl_reg;
    always @(posedge i_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            xs1_reg  <= 1'b0;
            xs2_reg  <= 1'b0;
            xs3_reg  <= 1'b0;
            xlvl_reg <= 1'b0;
        end
        else if (i_ce)
        begin
            xs1_reg <= i_xtal_osc;
            xs2_reg <= xs1_reg;
            xs3_reg <= xs2_reg;
            if (xs2_reg == xs3_reg)
                xlvl_reg <= xs3_reg;
        end
    end
    // A rise is counted only once two stages agree
    wire x_rise = (xs2_reg == xs3_reg) && xs3_reg && !xlvl_reg;

    // ****************************************
    // Registers and state
    // ****************************************
    localparam ST_RUN_INT  = 2'h0;
    localparam ST_WAIT_OSC = 2'h1;
    localparam ST_RUN_XTAL = 2'h2;
    localparam ST_SLEEP    = 2'h3;

    reg [1:0]       state_reg;
    reg [1:0]       state_next;
    reg [3:0]       cfg_reg;
    reg [CNT_W-1:0] ost_reg;
    reg             osc_done_reg;
    reg             pll_req_reg;
    reg             pll_rdy_reg;
    reg [7:0]       pll_cnt_reg;

    wire [2:0] mode = cfg_reg[`CSSU_CFG_MODE_MSB:`CSSU_CFG_MODE_LSB];
    wire xtal_mode = (mode == `CSSU_MODE_LP) || (mode == `CSSU_MODE_XT)
                     || (mode == `CSSU_MODE_HS);
    // Two-speed only with the config bit and a crystal mode
    wire two_speed = xtal_mode && cfg_reg[`CSSU_CFG_TWO_SPEED];
    wire ost_full  = (ost_reg == `CSSU_OSC_COUNT);

    wire wr_ctrl = i_avs_write && (i_avs_address == `CSSU_ADDR_CTRL);
    wire wr_cfg  = i_avs_write && (i_avs_address == `CSSU_ADDR_CFG);
    wire do_sleep = wr_ctrl && i_avs_writedata[`CSSU_CTRL_SLEEP];
    wire do_wake  = wr_ctrl && i_avs_writedata[`CSSU_CTRL_WAKE];

    // ****************************************
    // Start-up sequencer
    // ****************************************
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN_INT:
            begin
                if (do_sleep)
                    state_next = ST_SLEEP;
                else if (xtal_mode && ost_full)
                    state_next = ST_RUN_XTAL;
            end
            ST_WAIT_OSC:
            begin
                if (do_sleep)
                    state_next = ST_SLEEP;
                else if (ost_full)
                    state_next = ST_RUN_XTAL;
            end
            ST_RUN_XTAL:
            begin
                if (do_sleep)
                    state_next = ST_SLEEP;
                else if (!xtal_mode)
                    state_next = ST_RUN_INT;
            end
            ST_SLEEP:
            begin
                if (do_wake)
                begin
                    // Two-speed resumes on the RC clock at once
                    if (!xtal_mode || two_speed)
                        state_next = ST_RUN_INT;
                    else
                        state_next = ST_WAIT_OSC;
                end
            end
            default:
                state_next = ST_RUN_INT;
        endcase
    end

    always @(posedge i_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg    <= ST_RUN_INT;
            cfg_reg      <= `CSSU_CFG_RESET;
            ost_reg      <= {CNT_W{1'b0}};
            osc_done_reg <= 1'b0;
            pll_req_reg  <= 1'b0;
            pll_rdy_reg  <= 1'b0;
            pll_cnt_reg  <= 8'h00;
        end
        else if (i_ce)
        begin
            state_reg <= state_next;
            if (wr_cfg)
                cfg_reg <= i_avs_writedata[`CSSU_CFG_TWO_SPEED:`CSSU_CFG_MODE_LSB];
            if (wr_ctrl)
                pll_req_reg <= i_avs_writedata[`CSSU_CTRL_PLL_REQ];
            // Sleep aborts the count and keeps the flag low
            if (state_next == ST_SLEEP || !xtal_mode)
            begin
                ost_reg      <= {CNT_W{1'b0}};
                osc_done_reg <= 1'b0;
            end
            else if (!ost_full && x_rise)
                ost_reg <= ost_reg + 1'b1;
            else if (ost_full)
                osc_done_reg <= 1'b1;
            // PLL flag changes only after the lock delay elapses
            if (pll_req_reg == pll_rdy_reg)
                pll_cnt_reg <= 8'h00;
            else if (pll_cnt_reg == `CSSU_PLL_LOCK_CYC)
            begin
                pll_rdy_reg <= pll_req_reg;
                pll_cnt_reg <= 8'h00;
            end
            else
                pll_cnt_reg <= pll_cnt_reg + 8'h01;
        end
    end

    // ****************************************
    // Outputs and register reads
    // ****************************************
    always @(posedge i_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            o_sel_xtal     <= 1'b0;
            o_sel_pll      <= 1'b0;
            o_cpu_run      <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end
        else if (i_ce)
        begin
            o_sel_xtal <= (state_reg == ST_RUN_XTAL);
            o_sel_pll  <= pll_rdy_reg && (state_reg != ST_RUN_XTAL);
            o_cpu_run  <= (state_reg == ST_RUN_INT) || (state_reg == ST_RUN_XTAL);
            case (i_avs_address)
                `CSSU_ADDR_CTRL: o_avs_readdata <= {31'h0, pll_req_reg};
                `CSSU_ADDR_STAT: o_avs_readdata <= {26'h0,
                    !pll_rdy_reg,
                    (state_reg == ST_RUN_INT) || (state_reg == ST_RUN_XTAL),
                    (state_reg == ST_SLEEP),
                    (state_reg == ST_RUN_XTAL),
                    osc_done_reg,
                    pll_rdy_reg};
                `CSSU_ADDR_CFG:  o_avs_readdata <= {28'h0, cfg_reg};
                default:         o_avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // Fixed one-wait-state reads; writes complete at once
    reg rd_wait_reg;
    always @(posedge i_clk or negedge nrst)
    begin
        if (!nrst)
            rd_wait_reg <= 1'b0;
        else if (i_ce)
            rd_wait_reg <= i_avs_read && !rd_wait_reg;
    end
    assign o_avs_waitrequest = i_avs_read && !rd_wait_reg;

endmodule
`default_nettype wire

// file: include/cssu_regs.vh
`ifndef CSSU_REGS_VH
`define CSSU_REGS_VH

// ****************************************
// Register map (Avalon-MM, word addresses)
// ****************************************
`define CSSU_ADDR_W          2
`define CSSU_ADDR_CTRL       2'h0
`define CSSU_ADDR_STAT       2'h1
`define CSSU_ADDR_CFG        2'h2

// Control register fields
`define CSSU_CTRL_PLL_REQ    0
`define CSSU_CTRL_SLEEP      1
`define CSSU_CTRL_WAKE       2

// Config register fields
`define CSSU_CFG_MODE_LSB    0
`define CSSU_CFG_MODE_MSB    2
`define CSSU_CFG_TWO_SPEED   3

// Status register fields
`define CSSU_STAT_PLL_RDY    0
`define CSSU_STAT_OSC_DONE   1
`define CSSU_STAT_ON_XTAL    2
`define CSSU_STAT_ASLEEP     3
`define CSSU_STAT_RUNNING    4
`define CSSU_STAT_INT_RDY    5

// ****************************************
// Oscillator modes
// ****************************************
`define CSSU_MODE_LP         3'h0
`define CSSU_MODE_XT         3'h1
`define CSSU_MODE_HS         3'h2
`define CSSU_MODE_EXT        3'h3
`define CSSU_MODE_INT        3'h4

// ****************************************
// Timing
// ****************************************
`define CSSU_OSC_COUNT       11'h400
`define CSSU_PLL_LOCK_CYC    8'h10
`define CSSU_CFG_RESET       4'h4

`endif

// file: tb/cssu_props.sv
`timescale 1ns/1ps
`default_nettype none
module cssu_props (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_ce,
    input wire logic [1:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_sel_xtal,
    input wire logic        o_sel_pll,
    input wire logic        o_cpu_run
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst || !i_ce);
    wire logic cw = i_avs_write && i_avs_address == 2'h0;
    wire logic rk = i_avs_read && !o_avs_waitrequest;
    property p_wr; i_avs_write |-> !o_avs_waitrequest; endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_rd; i_avs_read && !$past(i_avs_read) |-> o_avs_waitrequest ##1 rk; endproperty
    a_rd: assert property (p_rd) else $error("read timing");
    property p_stat; rk && i_avs_address == 2'h1 |->
        o_avs_readdata[31:6] == 26'h0 && o_avs_readdata[5] != o_avs_readdata[0]; endproperty
    a_stat: assert property (p_stat) else $error("status bits");
    property p_excl; !(o_sel_pll && o_sel_xtal); endproperty
    a_excl: assert property (p_excl) else $error("two sources");
    property p_pll; cw && i_avs_writedata[0] && !o_sel_pll && !o_sel_xtal && o_cpu_run
        |-> (!o_sel_pll)[*8] ##[6:14] o_sel_pll; endproperty
    a_pll: assert property (p_pll) else $error("pll lock");
    property p_slp; cw && i_avs_writedata[1] |-> ##[1:3] !o_cpu_run; endproperty
    a_slp: assert property (p_slp) else $error("sleep ignored");
    property p_mode; i_avs_write && i_avs_address == 2'h2 && i_avs_writedata[2:0] > 3'h2
        |-> ##[1:3] !o_sel_xtal; endproperty
    a_mode: assert property (p_mode) else $error("crystal kept");
    property p_run; $rose(o_sel_xtal) |-> ##[0:3] o_cpu_run; endproperty
    a_run: assert property (p_run) else $error("no run on crystal");
    c_x: cover property ($rose(o_sel_xtal));
    c_p: cover property ($rose(o_sel_pll));
    c_s: cover property ($fell(o_cpu_run));
endmodule
bind cssu_clock_ctrl cssu_props u_props (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_sel_xtal(o_sel_xtal),
    .o_sel_pll(o_sel_pll),
    .o_cpu_run(o_cpu_run)
);
`default_nettype wire

// file: tb/cssu_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
// Each level lasts two clocks, so the input filter sees it settle
module cssu_xtal_model #(parameter int HALF = 40) (
    input  wire logic i_en,
    output var  logic o_osc
);
    // A crystal that is not powered stands still low
    initial o_osc = 1'b0;
    always
    begin
        #HALF;
        o_osc = i_en ? !o_osc : 1'b0;
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        tk = 1'b0;
    logic        xen = 1'b1;
    logic        ce = 1'b1;
    logic [1:0]  adr = 2'h0;
    logic [31:0] wd = 32'h0;
    wire         osc, wt, sx, sp, run;
    wire  [31:0] rdata;
    logic [31:0] q[$];
    int          mismatches = 0;
    int          check_count = 0;
    int          seed = 19627;
    int          n;
    initial forever #10 i_clk = !i_clk;
    cssu_clock_ctrl i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_xtal_osc(osc),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .o_sel_xtal(sx), .o_sel_pll(sp),
        .o_cpu_run(run));
    cssu_xtal_model i_xtal (.i_en(xen), .o_osc(osc));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        chk(q.size(), 32'h0);
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tmo(input int lim);
        if (n >= lim)
            chk(32'h0, 32'h1);
        if (n >= lim)
            print_verdict();
    endtask
    // Master holds the request until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
        n = 0;
        @(posedge i_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        // Waitrequest is read in the edge's time step, before the design updates
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (wt !== 1'b0 && n < 50);
        tmo(50);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rq(input logic [1:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wx();
        n = 0;
        while ((sx & run) !== 1'b1 && n < 6000)
        begin
            @(posedge i_clk);
            n++;
        end
        tmo(6000);
    endtask
    always @(negedge i_clk) tk <= rd && wt === 1'b0;
    always @(posedge i_clk)
        if (tk && q.size() > 0)
            chk(rdata, q.pop_front());
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        rq(2'h2, 32'h4);
        rq(2'h1, 32'h30);
        bus(1'b1, 2'h3, $random(seed));
        rq(2'h3, 32'h0);
        rq(2'h2, 32'h4);
        $display("Test map done");
        bus(1'b1, 2'h0, 32'h1);
        // A low clock enable must hold the lock count still
        ce <= 1'b0;
        repeat (30) @(posedge i_clk);
        chk(sp, 1'b0);
        ce <= 1'b1;
        repeat (25) @(posedge i_clk);
        rq(2'h1, 32'h11);
        chk(sp, 1'b1);
        bus(1'b1, 2'h0, 32'h0);
        repeat (25) @(posedge i_clk);
        rq(2'h1, 32'h30);
        chk(sp, 1'b0);
        $display("Test pll done");
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, 2'h2, 32'h8 | m);
            repeat (100 + ($random(seed) & 63)) @(posedge i_clk);
            rq(2'h1, 32'h30);
            bus(1'b1, 2'h0, 32'h2);
            xen <= 1'b0;
            rq(2'h1, 32'h28);
            bus(1'b1, 2'h0, 32'h4);
            xen <= 1'b1;
            rq(2'h1, 32'h30);
            if (m < 3)
                wx();
            rq(2'h1, m < 3 ? 32'h36 : 32'h30);
            bus(1'b1, 2'h2, 32'h4);
            rq(2'h1, 32'h30);
        end
        $display("Test modes done");
        bus(1'b1, 2'h2, 32'h1);
        wx();
        bus(1'b1, 2'h0, 32'h2);
        bus(1'b1, 2'h0, 32'h4);
        repeat (5) @(posedge i_clk);
        chk(run, 1'b0);
        chk(sx, 1'b0);
        wx();
        rq(2'h1, 32'h36);
        $display("Test slow wake done");
        repeat (2) @(posedge i_clk);
        print_verdict();
    end
endmodule
`default_nettype wire
